/* File: logic/ufs_pkg.sv */
// Package: register map, frame format layout and timing of the serial frame block
package ufs_pkg;

   // Register byte offsets
   localparam logic [7:0] ADDR_DATA = 8'h00;
   localparam logic [7:0] ADDR_FFC  = 8'h04;
   localparam logic [7:0] ADDR_CTRL = 8'h08;
   localparam logic [7:0] ADDR_BAUD = 8'h0C;
   localparam logic [7:0] ADDR_STAT = 8'h10;
   localparam logic [7:0] ADDR_ICLR = 8'h14;
   localparam logic [7:0] ADDR_IEN  = 8'h18;

   // Reset values and writable bits
   localparam logic [31:0] FFC_RESET  = 32'h0000_0000;
   localparam logic [31:0] FFC_WMASK  = 32'hF00F_FF7F;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   localparam logic [15:0] BAUD_RESET = 16'h0001;
   localparam logic [6:0]  STAT_RESET = 7'h00;
   localparam logic [6:0]  IEN_RESET  = 7'h00;

   // Oversampling and frame timing
   localparam logic [3:0] OS_MID         = 4'h7;
   localparam logic [3:0] OS_LAST        = 4'hF;
   localparam logic [3:0] BRK_BITS_SHORT = 4'hA;
   localparam logic [3:0] BRK_BITS_LONG  = 4'hB;

   // Frame format control, one field per documented bit group
   typedef struct packed {
      logic [3:0] node_id_upper;
      logic [7:0] rsvd_hi;
      logic       msb_first_select;
      logic       data_value_invert;
      logic       transmit_line_invert;
      logic       receive_line_invert;
      logic       pin_role_exchange;
      logic       lin_mode_enable;
      logic [1:0] stop_length_select;
      logic       serial_clock_output_enable;
      logic       serial_clock_idle_level;
      logic       serial_clock_capture_edge;
      logic       final_bit_pulse_enable;
      logic       rsvd_7;
      logic       break_interrupt_enable;
      logic       break_length_select;
      logic       node_id_width_select;
      logic [3:0] node_id_lower;
   } ufs_ffc_type;

   // General control
   typedef struct packed {
      logic [23:0] rsvd;
      logic [1:0]  data_len;
      logic        send_break;
      logic        receiver_mute;
      logic        addr_wake;
      logic        sync_mode;
      logic        rx_en;
      logic        tx_en;
   } ufs_ctrl_type;

   // Sticky events
   typedef struct packed {
      logic overrun;
      logic tx_empty;
      logic id_match;
      logic frame_err;
      logic brk_det;
      logic rx_ready;
      logic tx_done;
   } ufs_stat_type;

   // Data length code: 0 eight, 1 nine, 2 seven bits
   function automatic logic [3:0] data_bits(input logic [1:0] len);
      unique case (len)
         2'h1:    data_bits = 4'h9;
         2'h2:    data_bits = 4'h7;
         default: data_bits = 4'h8;
      endcase
   endfunction : data_bits

   // Break length in bit periods
   function automatic logic [3:0] brk_bits(input logic long_sel);
      brk_bits = long_sel ? BRK_BITS_LONG : BRK_BITS_SHORT;
   endfunction : brk_bits

endpackage : ufs_pkg

/* File: logic/ufs_rx.sv */
// Receive deframer with break detector, sampling at mid bit
`timescale 1ns/100ps
module ufs_rx import ufs_pkg::*; (
   // Clock and reset
   input  wire logic       pclk,
   input  wire logic       presetn,
   // Control
   input  wire logic       os_tick,
   input  wire logic       en,
   input  wire logic       rxb,
   input  wire logic [3:0] nbits,
   input  ufs_ffc_type     cfg,
   // Results
   output logic [8:0]      word,
   output logic            busy,
   output logic            valid,
   output logic            ferr,
   output logic            brk
);
   typedef enum logic [1:0] {
      R_IDLE  = 2'b00,
      R_START = 2'b01,
      R_DATA  = 2'b11,
      R_STOP  = 2'b10
   } ufs_rx_state_type;

   ufs_rx_state_type st_r;
   logic [3:0]       tick_r;
   logic [3:0]       idx_r;
   logic [8:0]       data_r;
   logic [7:0]       low_r;
   wire logic        b = rxb ^ cfg.data_value_invert;
   wire logic        smp = os_tick && tick_r == OS_LAST;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r   <= R_IDLE;
         tick_r <= 4'h0;
         idx_r  <= 4'h0;
         data_r <= 9'h000;
         valid  <= 1'b0;
         ferr   <= 1'b0;
      end else begin
         valid <= 1'b0;
         ferr  <= 1'b0;
         if (os_tick) begin
            tick_r <= tick_r + 4'h1;
         end
         unique case (st_r)
            R_IDLE: if (en && os_tick && !rxb) begin
               st_r   <= R_START;
               tick_r <= 4'h0;
            end
            R_START: if (os_tick && tick_r == OS_MID) begin
               // A start shorter than half a bit is a glitch
               st_r   <= rxb ? R_IDLE : R_DATA;
               tick_r <= 4'h0;
               idx_r  <= 4'h0;
               data_r <= 9'h000;
            end
            R_DATA: if (smp) begin
               if (cfg.msb_first_select) begin
                  data_r <= {data_r[7:0], b};
               end else begin
                  data_r[idx_r] <= b;
               end
               idx_r <= idx_r + 4'h1;
               if (idx_r == nbits - 4'h1) begin
                  st_r <= R_STOP;
               end
            end
            R_STOP: if (smp) begin
               st_r  <= R_IDLE;
               valid <= 1'b1;
               ferr  <= !rxb;
            end
         endcase
      end
   end

   // Break: low for the selected number of bit periods, LIN only
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         low_r <= 8'h00;
         brk   <= 1'b0;
      end else begin
         brk <= cfg.lin_mode_enable && en && os_tick && !rxb
                && low_r == {brk_bits(cfg.break_length_select), 4'h0} - 8'h01;
         if (!en || rxb) begin
            low_r <= 8'h00;
         end else if (os_tick && low_r != 8'hFF) begin
            low_r <= low_r + 8'h01;
         end
      end
   end

   assign word = data_r;
   assign busy = st_r != R_IDLE;

endmodule : ufs_rx

/* File: logic/ufs_top.sv */
// Serial frame block: APB registers, pin routing, clock output, events and interrupt
//
// Operation
// - Node id held as upper nibble in bits 31:28, lower in 3:0.
// - Bit order select: zero sends LSB first, one sends MSB first.
// - Data inversion flips data bit values both on transmit and receive.
// - Transmit and receive line inversion, each for its direction, make idle low and space high when set.
// - Pin swap exchanges the transmit and receive pin roles.
// - LIN behaviour, break detection, only while LIN enable is set.
// - Stop length code: 00 one, 01 half, 10 two, 11 one and half.
// - Serial clock pin driven in synchronous mode only when enabled.
// - Clock idle level low for zero, high for one.
// - Capture edge: first clock edge of a bit, or the second.
// - Clock pulse of last data bit only when enabled.
// - Break interrupt raised only while break interrupt enable is set.
// - Break length ten bits for zero, eleven bits for one.
// - Compared id four bits, or data width minus one bits.
// - Address wakeup: id match leaves mute, mismatch re-enters mute.
`timescale 1ns/100ps
module ufs_top import ufs_pkg::*; (
   // APB slave
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Line pins, transmit by default on a, receive on b
   input  wire logic        pin_a_in,
   output logic             pin_a_out,
   output logic             pin_a_oe,
   input  wire logic        pin_b_in,
   output logic             pin_b_out,
   output logic             pin_b_oe,
   // Serial clock pin
   output logic             sclk_out,
   output logic             sclk_oe,
   // Interrupt
   output logic             irq
);
   ufs_ffc_type  ffc_r;
   ufs_ctrl_type ctrl_r;
   ufs_ctrl_type ctrl_nxt;
   ufs_stat_type stat_r;
   ufs_stat_type ev;
   logic [6:0]   ien_r;
   logic [6:0]   igate;
   logic [15:0]  baud_r;
   logic [15:0]  div_r;
   logic         os_tick_r;
   logic [8:0]   txd_r;
   logic         tx_pend_r;
   logic [8:0]   rxd_r;
   logic [31:0]  prdata_r;
   logic         pready_r;
   logic         pslverr_r;
   logic         irq_r;
   logic [1:0]   sync_a_r;
   logic [1:0]   sync_b_r;
   logic         pin_a_out_r;
   logic         pin_a_oe_r;
   logic         pin_b_out_r;
   logic         pin_b_oe_r;
   logic         sclk_out_r;
   logic         sclk_oe_r;
   logic [31:0]  rd_mux;
   logic         addr_ok;

   // Datapath signals
   logic [3:0]   nbits;
   logic         tx_busy;
   logic         tx_done;
   logic         tx_line;
   logic         tx_clk;
   logic         tx_kick;
   logic         rx_bit;
   logic [8:0]   rx_word;
   logic         rx_busy;
   logic         rx_vld;
   logic         rx_ferr;
   logic         rx_brk;
   logic         rx_addr;
   logic         hit;
   logic         mute_set;
   logic         mute_clr;
   logic         deliver;

   wire logic    acc  = psel && penable && pready_r;
   wire logic    wr   = acc && pwrite;
   wire logic    setup_rd = psel && penable && !pready_r;

   // Identifier compare, width chosen by the id width select
   function automatic logic id_hit(input logic [8:0] d, input ufs_ffc_type c,
                                   input logic [3:0] nb);
      logic [8:0] mask;
      logic [8:0] id;
      mask = 9'h000;
      id   = {1'b0, c.node_id_upper, c.node_id_lower};
      if (c.node_id_width_select) begin
         mask = (9'h001 << (nb - 4'h1)) - 9'h001;
      end else begin
         mask = 9'h00F;
      end
      id_hit = ((d ^ id) & mask) == 9'h000;
   endfunction : id_hit

   assign nbits = data_bits(ctrl_r.data_len);

   // APB answers one cycle into the access phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_r  <= 1'b0;
         prdata_r  <= 32'h0000_0000;
         pslverr_r <= 1'b0;
      end else begin
         pready_r  <= setup_rd;
         prdata_r  <= 32'h0000_0000;
         pslverr_r <= 1'b0;
         if (setup_rd) begin
            prdata_r  <= pwrite ? 32'h0000_0000 : rd_mux;
            pslverr_r <= !addr_ok;
         end
      end
   end

   always_comb begin
      addr_ok = 1'b1;
      rd_mux  = 32'h0000_0000;
      unique case (paddr)
         ADDR_DATA: rd_mux = {23'h000000, rxd_r};
         ADDR_FFC:  rd_mux = ffc_r;
         ADDR_CTRL: rd_mux = ctrl_r;
         ADDR_BAUD: rd_mux = {16'h0000, baud_r};
         ADDR_STAT: rd_mux = {21'h000000, rx_busy, tx_pend_r, tx_busy, 1'b0, stat_r};
         ADDR_ICLR: rd_mux = 32'h0000_0000;
         ADDR_IEN:  rd_mux = {25'h0000000, ien_r};
         default:   addr_ok = 1'b0;
      endcase
   end

   // Frame format register; reserved bits always stored as zero
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ffc_r <= FFC_RESET;
      end else if (wr && paddr == ADDR_FFC) begin
         ffc_r <= pwdata & FFC_WMASK;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         baud_r <= BAUD_RESET;
      end else if (wr && paddr == ADDR_BAUD) begin
         baud_r <= (pwdata[15:0] == 16'h0000) ? BAUD_RESET : pwdata[15:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ien_r <= IEN_RESET;
      end else if (wr && paddr == ADDR_IEN) begin
         ien_r <= pwdata[6:0];
      end
   end

   // Control: hardware owns the mute bit over a same-cycle write
   always_comb begin
      ctrl_nxt = ctrl_r;
      if (tx_kick && ctrl_r.send_break) begin
         ctrl_nxt.send_break = 1'b0;
      end
      if (wr && paddr == ADDR_CTRL) begin
         ctrl_nxt      = pwdata;
         ctrl_nxt.rsvd = 24'h000000;
      end
      if (mute_set) begin
         ctrl_nxt.receiver_mute = 1'b1;
      end else if (mute_clr) begin
         ctrl_nxt.receiver_mute = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r <= CTRL_RESET;
      end else begin
         ctrl_r <= ctrl_nxt;
      end
   end

   // Oversampling tick, sixteen per bit
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_r     <= 16'h0000;
         os_tick_r <= 1'b0;
      end else begin
         os_tick_r <= div_r == baud_r - 16'h0001;
         div_r     <= (div_r >= baud_r - 16'h0001) ? 16'h0000 : div_r + 16'h0001;
      end
   end

   // Transmit holding word; a write while pending replaces it
   assign tx_kick = ctrl_r.tx_en && !tx_busy && (tx_pend_r || ctrl_r.send_break);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         txd_r     <= 9'h000;
         tx_pend_r <= 1'b0;
      end else if (wr && paddr == ADDR_DATA) begin
         txd_r     <= pwdata[8:0];
         tx_pend_r <= 1'b1;
      end else if (tx_kick && !ctrl_r.send_break) begin
         tx_pend_r <= 1'b0;
      end
   end

   ufs_tx u_tx (
      .pclk    (pclk),
      .presetn (presetn),
      .os_tick (os_tick_r),
      .start   (tx_kick),
      .brk     (ctrl_r.send_break),
      .data    (txd_r),
      .nbits   (nbits),
      .cfg     (ffc_r),
      .busy    (tx_busy),
      .done    (tx_done),
      .line    (tx_line),
      .clk_act (tx_clk)
   );

   // Both pins synchronised, the swap picks one after the second stage
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync_a_r <= 2'b11;
         sync_b_r <= 2'b11;
      end else begin
         sync_a_r <= {sync_a_r[0], pin_a_in};
         sync_b_r <= {sync_b_r[0], pin_b_in};
      end
   end

   assign rx_bit = (ffc_r.pin_role_exchange ? sync_a_r[1] : sync_b_r[1])
                   ^ ffc_r.receive_line_invert;

   ufs_rx u_rx (
      .pclk    (pclk),
      .presetn (presetn),
      .os_tick (os_tick_r),
      .en      (ctrl_r.rx_en),
      .rxb     (rx_bit),
      .nbits   (nbits),
      .cfg     (ffc_r),
      .word    (rx_word),
      .busy    (rx_busy),
      .valid   (rx_vld),
      .ferr    (rx_ferr),
      .brk     (rx_brk)
   );

   // Address frames carry the top data bit set
   always_comb begin
      rx_addr  = ctrl_r.addr_wake && rx_word[nbits - 4'h1];
      hit      = id_hit(rx_word, ffc_r, nbits);
      mute_set = rx_vld && rx_addr && !hit;
      mute_clr = rx_vld && rx_addr && hit;
      deliver  = rx_vld && !(mute_set || (ctrl_r.receiver_mute && !mute_clr));
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rxd_r <= 9'h000;
      end else if (deliver) begin
         rxd_r <= rx_word;
      end
   end

   // Events; a set in the clearing cycle wins
   always_comb begin
      ev           = '0;
      ev.tx_done   = tx_done;
      ev.rx_ready  = deliver;
      ev.brk_det   = rx_brk;
      ev.frame_err = rx_vld && rx_ferr && !rx_brk;
      ev.id_match  = mute_clr;
      ev.tx_empty  = tx_kick && !ctrl_r.send_break;
      ev.overrun   = deliver && stat_r.rx_ready;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stat_r <= STAT_RESET;
      end else if (wr && paddr == ADDR_ICLR) begin
         stat_r <= (stat_r & ~pwdata[6:0]) | ev;
      end else begin
         stat_r <= stat_r | ev;
      end
   end

   always_comb begin
      igate         = 7'h7F;
      igate[2]      = ffc_r.break_interrupt_enable;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= |(stat_r & ien_r & igate);
      end
   end

   // Pin drivers; the idle level follows the line inversion
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_a_out_r <= 1'b1;
         pin_a_oe_r  <= 1'b0;
         pin_b_out_r <= 1'b1;
         pin_b_oe_r  <= 1'b0;
      end else begin
         pin_a_out_r <= tx_line ^ ffc_r.transmit_line_invert;
         pin_b_out_r <= tx_line ^ ffc_r.transmit_line_invert;
         pin_a_oe_r  <= ctrl_r.tx_en && !ffc_r.pin_role_exchange;
         pin_b_oe_r  <= ctrl_r.tx_en && ffc_r.pin_role_exchange;
      end
   end

   // Clock pin is a master output only
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sclk_out_r <= 1'b0;
         sclk_oe_r  <= 1'b0;
      end else begin
         sclk_oe_r  <= ctrl_r.sync_mode && ffc_r.serial_clock_output_enable;
         sclk_out_r <= ffc_r.serial_clock_idle_level
                       ^ (tx_clk && ctrl_r.sync_mode);
      end
   end

   assign prdata    = prdata_r;
   assign pready    = pready_r;
   assign pslverr   = pslverr_r;
   assign irq       = irq_r;
   assign pin_a_out = pin_a_out_r;
   assign pin_a_oe  = pin_a_oe_r;
   assign pin_b_out = pin_b_out_r;
   assign pin_b_oe  = pin_b_oe_r;
   assign sclk_out  = sclk_out_r;
   assign sclk_oe   = sclk_oe_r;

endmodule : ufs_top

/* File: logic/ufs_tx.sv */
// Transmit framer: start, data, break and fractional stop periods
`timescale 1ns/100ps
module ufs_tx import ufs_pkg::*; (
   // Clock and reset
   input  wire logic       pclk,
   input  wire logic       presetn,
   // Control
   input  wire logic       os_tick,
   input  wire logic       start,
   input  wire logic       brk,
   input  wire logic [8:0] data,
   input  wire logic [3:0] nbits,
   input  ufs_ffc_type     cfg,
   // Status and line
   output logic            busy,
   output logic            done,
   output logic            line,
   output logic            clk_act
);
   typedef enum logic [1:0] {
      T_IDLE  = 2'b00,
      T_START = 2'b01,
      T_DATA  = 2'b11,
      T_STOP  = 2'b10
   } ufs_tx_state_type;

   ufs_tx_state_type st_r;
   logic [3:0]       tick_r;
   logic [3:0]       idx_r;
   logic [3:0]       last_r;
   logic [2:0]       half_r;
   logic [8:0]       data_r;
   logic             brk_r;
   logic             dbit;
   wire logic        bit_end  = os_tick && tick_r == OS_LAST;
   wire logic        half_end = os_tick && tick_r[2:0] == OS_MID[2:0];

   // Stop length in half bits, counted on the oversampling ticks
   function automatic logic [2:0] stop_halves(input logic [1:0] sel);
      unique case (sel)
         2'h0: stop_halves = 3'h2;
         2'h1: stop_halves = 3'h1;
         2'h2: stop_halves = 3'h4;
         2'h3: stop_halves = 3'h3;
      endcase
   endfunction : stop_halves

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_r <= 4'h0;
      end else if (st_r == T_IDLE) begin
         tick_r <= 4'h0;
      end else if (os_tick) begin
         tick_r <= tick_r + 4'h1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r   <= T_IDLE;
         idx_r  <= 4'h0;
         last_r <= 4'h0;
         half_r <= 3'h0;
         data_r <= 9'h000;
         brk_r  <= 1'b0;
      end else begin
         unique case (st_r)
            T_IDLE: if (start) begin
               st_r   <= T_START;
               idx_r  <= 4'h0;
               data_r <= data;
               brk_r  <= brk;
               last_r <= brk ? brk_bits(cfg.break_length_select) - 4'h2
                             : nbits - 4'h1;
            end
            T_START: if (bit_end) begin
               st_r <= T_DATA;
            end
            T_DATA: if (bit_end) begin
               if (idx_r == last_r) begin
                  st_r   <= T_STOP;
                  half_r <= stop_halves(cfg.stop_length_select);
               end else begin
                  idx_r <= idx_r + 4'h1;
               end
            end
            T_STOP: if (half_end) begin
               half_r <= half_r - 3'h1;
               if (half_r == 3'h1) begin
                  st_r <= T_IDLE;
               end
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         done <= 1'b0;
      end else begin
         done <= st_r == T_STOP && half_end && half_r == 3'h1;
      end
   end

   always_comb begin
      dbit    = cfg.msb_first_select ? data_r[last_r - idx_r] : data_r[idx_r];
      line    = 1'b1;
      clk_act = 1'b0;
      if (st_r == T_START) begin
         line = 1'b0;
      end else if (st_r == T_DATA) begin
         line    = brk_r ? 1'b0 : dbit ^ cfg.data_value_invert;
         clk_act = !brk_r && (tick_r[3] ^ cfg.serial_clock_capture_edge)
                   && (idx_r != last_r || cfg.final_bit_pulse_enable);
      end
   end

   assign busy = st_r != T_IDLE;

endmodule : ufs_tx

/* File: testbench/tb_uart_frame_sync_config.sv */
// Bench: registers, frames both ways, interrupt
`timescale 1ns/100ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin error_cnt++; \
   $display("MISMATCH %0t got %h", $time, a); end end
module tb_uart_frame_sync_config import ufs_pkg::*;;
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic        pready, pslverr, a_out, a_oe, b_out, b_oe, irq, ntx, line, err, swap = 1'b0;
   logic        sclk, sclk_e, sclk_q;
   logic [7:0]  paddr = 8'h00, d, got;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rd, w;
   int          error_cnt = 0, n_compared = 0, n;
   // Pull-up where no one drives
   assign line = swap ? (b_oe ? b_out : 1'b1) : (a_oe ? a_out : 1'b1);
   ufs_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .pin_a_in(a_oe ? a_out : ntx), .pin_a_out(a_out), .pin_a_oe(a_oe),
      .pin_b_in(b_oe ? b_out : ntx), .pin_b_out(b_out), .pin_b_oe(b_oe),
      .sclk_out(sclk), .sclk_oe(sclk_e), .irq(irq));
   ufs_node node (.pclk(pclk), .rxl(line), .txl(ntx));
   initial forever #2 pclk = ~pclk;
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] v);
      @(posedge pclk);
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= a;
      pwdata <= v;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk iff pready === 1'b1);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   function automatic logic [7:0] xf(input logic [7:0] v, input logic m, input logic n);
      logic [7:0] x;
      x = n ? ~v : v;
      if (m) xf = {<<{x}};
      else xf = x;
   endfunction : xf
   task automatic give_verdict;
      $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : give_verdict
   initial begin
      #200000;
      error_cnt++;
      give_verdict();
   end
   initial begin
      void'($urandom(29901));
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, ADDR_FFC, 32'h0000_0000);
      `CHK(rd, FFC_RESET)
      w = $urandom & FFC_WMASK;
      apb(1'b1, ADDR_FFC, w);
      apb(1'b0, ADDR_FFC, 32'h0000_0000);
      `CHK(rd, w)
      apb(1'b0, 8'h40, 32'h0000_0000);
      `CHK(err, 1'b1)
      apb(1'b1, ADDR_CTRL, 32'h0000_0003);
      // Clock shape bits stay zero while sending
      for (int i = 0; i < 32; i++) begin
         node.en <= 1'b0;
         apb(1'b1, ADDR_FFC, {12'h000, i[4:0], 15'h0000});
         repeat (2) @(posedge pclk);
         swap <= i[0];
         node.ii <= i[2];
         node.io <= i[1];
         node.txl <= ~i[1];
         repeat (4) @(posedge pclk);
         node.en <= 1'b1;
         d = 8'($urandom);
         apb(1'b1, ADDR_DATA, {24'h000000, d});
         for (int t = 0; t < 400 && node.q.size() == 0; t++) @(posedge pclk);
         // An empty queue is a timeout and must mismatch
         got = (node.q.size() != 0) ? node.q.pop_front() : ~xf(d, i[4], i[3]);
         `CHK(got, xf(d, i[4], i[3]))
         d = 8'($urandom);
         node.send(d);
         apb(1'b0, ADDR_DATA, 32'h0000_0000);
         `CHK(rd[7:0], xf(d, i[4], i[3]))
      end
      apb(1'b1, ADDR_IEN, 32'h0000_0001);
      apb(1'b0, ADDR_STAT, 32'h0000_0000);
      `CHK({irq, rd[0]}, 2'b11)
      apb(1'b1, ADDR_IEN, 32'h0000_0000);
      repeat (3) @(posedge pclk);
      `CHK(irq, 1'b0)
      apb(1'b1, ADDR_IEN, 32'h0000_0001);
      apb(1'b1, ADDR_ICLR, 32'h0000_0001);
      repeat (3) @(posedge pclk);
      `CHK(irq, 1'b0)
      // Long break in LIN mode: no flag at 170 clocks low, flag by 185
      node.txl <= 1'b1;
      apb(1'b1, ADDR_FFC, 32'h0000_4060);
      apb(1'b1, ADDR_IEN, 32'h0000_0004);
      node.txl <= 1'b0;
      repeat (170) @(posedge pclk);
      `CHK(irq, 1'b0)
      repeat (15) @(posedge pclk);
      `CHK(irq, 1'b1)
      apb(1'b1, ADDR_FFC, 32'h0000_4020);
      repeat (2) @(posedge pclk);
      `CHK(irq, 1'b0)
      node.txl <= 1'b1;
      // Clock shape changed only with the transmitter off
      for (int j = 0; j < 2; j++) begin
         apb(1'b1, ADDR_CTRL, 32'h0000_0000);
         apb(1'b1, ADDR_FFC, {20'h00000, 3'b110, j[0], 8'h00});
         `CHK(sclk_e, 1'b0)
         apb(1'b1, ADDR_CTRL, 32'h0000_0005);
         repeat (2) @(posedge pclk);
         `CHK({sclk_e, sclk}, 2'b11)
         n = 0;
         sclk_q = 1'b1;
         apb(1'b1, ADDR_DATA, 32'h0000_0000);
         repeat (200) begin
            @(posedge pclk);
            n += int'(sclk_q && !sclk);
            sclk_q = sclk;
         end
         `CHK(n, 7 + j)
      end
      give_verdict();
   end
endmodule : tb_uart_frame_sync_config
bind ufs_top ufs_sva chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .pin_a_oe(pin_a_oe), .pin_b_oe(pin_b_oe));

/* File: testbench/ufs_node.sv */
// Partner node: frame sender and catcher on the line
`timescale 1ns/100ps
module ufs_node (
   // Line
   input  wire logic pclk,
   input  wire logic rxl,
   output logic      txl
);
   logic       en = 1'b0;
   logic       ii = 1'b0;
   logic       io = 1'b0;
   logic [7:0] sh;
   logic [7:0] q[$];
   logic [9:0] f;
   initial txl = 1'b1;
   // Bit period fixed at 16 clocks, so the rate register stays at reset
   initial forever begin
      @(posedge pclk iff en && (rxl ^ ii) == 1'b0);
      repeat (8) @(posedge pclk);
      for (int k = 0; k < 8; k++) begin
         repeat (16) @(posedge pclk);
         sh[k] = rxl ^ ii;
      end
      repeat (16) @(posedge pclk);
      q.push_back(sh);
   end
   task automatic send(input logic [7:0] v);
      f = {1'b1, v, 1'b0};
      for (int k = 0; k < 10; k++) begin
         txl <= f[k] ^ io;
         repeat (16) @(posedge pclk);
      end
   endtask : send
endmodule : ufs_node

/* File: testbench/ufs_sva.sv */
// Checker: bus handshake, read data and pin enables
`timescale 1ns/100ps
module ufs_sva import ufs_pkg::*; (
   // Bus
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // Pins
   input wire logic        pin_a_oe,
   input wire logic        pin_b_oe
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_once; pready |=> !pready; endproperty
   a_once: assert property (p_once) else $error("pready held");
   property p_wait; psel && penable && !$past(penable) |-> !pready ##1 pready; endproperty
   a_wait: assert property (p_wait) else $error("wait states");
   property p_acc; pready |-> psel && penable; endproperty
   a_acc: assert property (p_acc) else $error("pready outside access");
   property p_err; pslverr |-> pready; endproperty
   a_err: assert property (p_err) else $error("pslverr alone");
   property p_idle; !pready |-> prdata == 32'h0000_0000; endproperty
   a_idle: assert property (p_idle) else $error("prdata outside answer");
   property p_unmap; pready && paddr > ADDR_IEN |-> pslverr; endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped accepted");
   property p_map; pready && paddr == ADDR_FFC |-> !pslverr; endproperty
   a_map: assert property (p_map) else $error("format refused");
   property p_oe; !(pin_a_oe && pin_b_oe); endproperty
   a_oe: assert property (p_oe) else $error("both pins driven");
endmodule : ufs_sva
